// *** inc/isr_seq_pkg.sv ***
// Package for the interrupt entry and return sequencer.
// Assumes one instruction clock; all widths are shared by both design files.
package isr_seq_pkg;
  localparam int PC_W = 21;
  localparam int VEC_W = 8;
  localparam int SRC_W = 64;
  localparam int CTX_W = 96;           // Status, working, bank, pointers, product, latches
  localparam logic [3:0] VEC_CYCLES = 4'h3;  // Vectored entry latency
  localparam logic [3:0] PLAIN_CYCLES = 4'h2; // Single entry point latency
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] ENTRY_ADDR = 21'h000008;
  localparam logic [PC_W-1:0] VEC_BASE_RESET = 21'h000008;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_LAT1 = 3'b010,
    ST_LAT2 = 3'b011,
    ST_LAT3 = 3'b100
  } seq_state_t;

  // Core context that is shadowed on entry; its pc comes back on every return, the rest only when restoreCtx is set
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [CTX_W-1:0] core;
  } ctx_t;

  // Return request from the pipeline
  typedef struct packed {
    logic valid;
    logic restoreCtx;
  } ret_req_t;
endpackage

// *** hdl/vector_encoder.sv ***
// Priority encoder turning pending interrupt flags into a vector number.
// Assumes flags are already synchronous to the instruction clock.
`timescale 1ns/1ps
`default_nettype none
module vector_encoder #(
  parameter int SRC = 64,
  parameter int VW = 8
) (
  input wire logic [SRC-1:0] flags,
  output logic anyPending,
  output logic [VW-1:0] vecNum
);
  // Lowest index wins; scanning from the top lets it overwrite
  always_comb begin
    vecNum = '0;
    for (int i = SRC - 1; i >= 0; i--) begin
      if (flags[i]) begin
        vecNum = VW'(i);
      end
    end
  end
  assign anyPending = |flags;
endmodule
`default_nettype wire

// *** hdl/interrupt_entry_return_sequencer.sv ***
// Interrupt entry and return sequencer for the core pipeline.
// Assumes flags and controls come from logic on sys_clk; the pipeline
// reports the end of each instruction with instrDone.
// Assumes the vector table answers tableAddr within the same cycle and
// that the core copies shadowCtx back whenever ctxRestore pulses.
// Only one routine level is held, so flags are ignored while inIsr stands.
// The core must honour forced_no_operation in every latency slot.
`timescale 1ns/1ps
`default_nettype none
module interrupt_entry_return_sequencer #(
  parameter int SRC = isr_seq_pkg::SRC_W,
  parameter int VW = isr_seq_pkg::VEC_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [SRC-1:0] irqFlags,
  input wire logic globalEnable,
  input wire logic multi_vector_enable,
  input wire logic [isr_seq_pkg::PC_W-1:0] vector_table_base,
  input wire logic instrDone,
  input wire isr_seq_pkg::ctx_t liveCtx,
  input wire isr_seq_pkg::ret_req_t return_from_isr_instr,
  input wire logic [isr_seq_pkg::PC_W-1:0] tableData,
  output logic forced_no_operation,
  output logic [isr_seq_pkg::PC_W-1:0] tableAddr,
  output logic tableRead,
  output logic pcLoad,
  output logic [isr_seq_pkg::PC_W-1:0] pcValue,
  output logic pushPc,
  output logic popPc,
  output logic ctxRestore,
  output isr_seq_pkg::ctx_t shadowCtx,
  output logic [VW-1:0] activeVector,
  output logic inIsr
);
  // Walk state and the encoder's answer
  isr_seq_pkg::seq_state_t state_reg, state_next;
  logic anyPending;
  logic [VW-1:0] vecNum;
  // Entry address and the single saved return address
  logic [isr_seq_pkg::PC_W-1:0] vecAddr;
  logic [isr_seq_pkg::PC_W-1:0] stackTop_reg;
  // Accepted requests
  logic takeIrq;
  logic doReturn;
  // Decoded slots
  logic inLat1;
  logic inLat2;
  logic inLat3;
  logic nextLat1;
  logic nextLat2;
  logic nextLat3;
  logic captureCtx;
  logic fnopNext;
  // Next values of the registered outputs
  logic loadTable;
  logic loadRoutine;
  logic loadEntry;
  logic loadReturn;
  logic pcLoadNext;
  logic ctxRestoreNext;
  logic inIsrNext;
  logic [isr_seq_pkg::PC_W-1:0] pcValueNext;

  // The encoder is pure logic on the raw flags; its vector number is only
  // used as the walk starts, so a flag that drops during the slots is harmless
  vector_encoder #(.SRC(SRC), .VW(VW)) encoder (
    .flags(irqFlags),
    .anyPending(anyPending),
    .vecNum(vecNum)
  );

  // Entry is taken for any enabled pending flag outside a routine, even mid-instruction;
  // nesting is refused, since the shadow copy holds a single level
  assign takeIrq = anyPending && globalEnable && !inIsr;
  // A return is only honoured from the run state while a routine is active
  assign doReturn = return_from_isr_instr.valid && inIsr && state_reg == isr_seq_pkg::ST_RUN;
  // Vector table entry address: base plus twice the vector number (word-sized entries);
  // the carry out of the top bit is dropped, so the table wraps at the top
  assign vecAddr = vector_table_base
    + isr_seq_pkg::PC_W'({vecNum, 1'b0});

  // Next state: vectored mode walks three cycles, plain mode two.
  // Vectored walk: LAT1 saves, LAT2 reads the table, LAT3 jumps to the routine.
  // Plain walk skips LAT2: LAT1 saves and loads the entry point, LAT3 settles.
  // WAIT holds a taken request until the running instruction ends, so a
  // long instruction only delays the start, never the length of the walk.
  always_comb begin
    // Hold unless a transition below applies
    state_next = state_reg;
    unique case (state_reg)
      isr_seq_pkg::ST_RUN: begin
        // A return in the same cycle wins over a new entry
        if (takeIrq && !doReturn) begin
          state_next = instrDone ? isr_seq_pkg::ST_LAT1 : isr_seq_pkg::ST_WAIT;
        end
      end
      isr_seq_pkg::ST_WAIT: begin
        // The request is already taken; only the instruction end is awaited
        if (instrDone) begin
          state_next = isr_seq_pkg::ST_LAT1;
        end
      end
      isr_seq_pkg::ST_LAT1: begin
        // Mode is read here; the walk length follows from it
        state_next = multi_vector_enable ? isr_seq_pkg::ST_LAT2 : isr_seq_pkg::ST_LAT3;
      end
      isr_seq_pkg::ST_LAT2: begin
        // Table read slot, present only in vectored mode
        state_next = isr_seq_pkg::ST_LAT3;
      end
      isr_seq_pkg::ST_LAT3: begin
        // Last slot of either walk
        state_next = isr_seq_pkg::ST_RUN;
      end
      default: begin
        // Codes 5 to 7 are unused; fall back to the run state
        state_next = isr_seq_pkg::ST_RUN;
      end
    endcase
  end

  // Decoded latency slots; the registered slot strobes below read these rather than the state code,
  // which keeps the clocked processes short
  assign inLat1 = state_reg == isr_seq_pkg::ST_LAT1;
  assign inLat2 = state_reg == isr_seq_pkg::ST_LAT2;
  assign inLat3 = state_reg == isr_seq_pkg::ST_LAT3;
  assign nextLat1 = state_next == isr_seq_pkg::ST_LAT1;
  assign nextLat2 = state_next == isr_seq_pkg::ST_LAT2;
  assign nextLat3 = state_next == isr_seq_pkg::ST_LAT3;

  // Context is caught on the step into the first slot only; catching it
  // later would save a pc that the walk has already overwritten
  assign captureCtx = nextLat1 && !inLat1;
  // Every slot of either walk is squashed in the pipeline
  assign fnopNext = nextLat1 || nextLat2 || nextLat3;

  // Program counter sources; at most one is live in any cycle, because the
  // slots are exclusive and a return is only accepted in the run state
  assign loadTable = inLat1 && multi_vector_enable;
  assign loadRoutine = inLat2;
  assign loadEntry = inLat1 && !multi_vector_enable;
  assign loadReturn = doReturn;
  assign pcLoadNext = loadTable || loadRoutine || loadEntry || loadReturn;
  // The table answers in the same cycle, so its data is taken as LAT2 ends
  assign pcValueNext = loadTable ? tableAddr
    : loadRoutine ? tableData
    : loadEntry ? isr_seq_pkg::ENTRY_ADDR
    : loadReturn ? stackTop_reg
    : pcValue;
  // Operand 0 still pops the pc but leaves the core registers alone
  assign ctxRestoreNext = loadReturn && return_from_isr_instr.restoreCtx;
  // Routine flag: set as the last slot ends, cleared by an accepted return
  assign inIsrNext = inLat3 || (inIsr && !loadReturn);

  // State and entry-side outputs, all registered so the core sees
  // clean levels straight from flip-flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= isr_seq_pkg::ST_RUN;
      forced_no_operation <= 1'b0;
      tableAddr <= isr_seq_pkg::PC_RESET;
      tableRead <= 1'b0;
      pushPc <= 1'b0;
      activeVector <= '0;
    end else begin
      state_reg <= state_next;
      forced_no_operation <= fnopNext;
      pushPc <= nextLat1;
      tableRead <= nextLat2;
      if (captureCtx) begin
        tableAddr <= vecAddr;
        activeVector <= vecNum;
      end
    end
  end

  // Shadow copy of the context; a single level, as nesting is refused,
  // and it stands until the next entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shadowCtx <= '0;
      stackTop_reg <= isr_seq_pkg::PC_RESET;
    end else if (captureCtx) begin
      shadowCtx <= liveCtx;
      stackTop_reg <= liveCtx.pc;
    end
  end

  // Program counter loads: table address, routine start, or return target;
  // pcValue holds between loads so the core may sample it late
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Reset leaves no load pending, so the core sees a quiet port
      pcLoad <= 1'b0;
      pcValue <= isr_seq_pkg::PC_RESET;
      popPc <= 1'b0;
      ctxRestore <= 1'b0;
      inIsr <= 1'b0;
    end else begin
      pcLoad <= pcLoadNext;
      pcValue <= pcValueNext;
      popPc <= loadReturn;
      ctxRestore <= ctxRestoreNext;
      inIsr <= inIsrNext;
    end
  end
endmodule
`default_nettype wire

// *** verif/isr_seq_monitor.sv ***
// Port checker for the interrupt sequencer.
// Assumes it is bound onto the sequencer top module.
`timescale 1ns/1ps
`default_nettype none
module isr_seq_monitor #(parameter int SRC = 64) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [SRC-1:0] irqFlags,
  input wire logic globalEnable,
  input wire logic multi_vector_enable,
  input wire logic [20:0] vector_table_base,
  input wire logic instrDone,
  input wire isr_seq_pkg::ctx_t liveCtx,
  input wire isr_seq_pkg::ret_req_t return_from_isr_instr,
  input wire logic [20:0] tableData,
  input wire logic forced_no_operation,
  input wire logic [20:0] tableAddr,
  input wire logic tableRead,
  input wire logic pcLoad,
  input wire logic [20:0] pcValue,
  input wire logic pushPc,
  input wire logic popPc,
  input wire logic ctxRestore,
  input wire isr_seq_pkg::ctx_t shadowCtx,
  input wire logic [7:0] activeVector,
  input wire logic inIsr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  int lowIdx;
  logic take;
  // Scan downward so the smallest pending index is left behind
  always_comb begin
    lowIdx = 0;
    for (int i = SRC - 1; i >= 0; i--) if (irqFlags[i]) lowIdx = i;
  end
  // Busy cycles are excluded so a late instruction end is not read as a new entry
  assign take = |irqFlags && globalEnable && instrDone && !inIsr
    && !(forced_no_operation || pcLoad || pushPc);
  AST_ENTRY: assert property (take |=> pushPc && shadowCtx == $past(liveCtx))
    else $error("entry missed or context not saved");
  AST_WAIT: assert property (|irqFlags && !instrDone && !inIsr && !pcLoad |=> !pushPc)
    else $error("entry began before instruction end");
  AST_ADDR: assert property (take && multi_vector_enable
    |=> tableAddr == $past(vector_table_base) + 21'(2 * $past(lowIdx)))
    else $error("vector table address wrong");
  AST_ACTIVE: assert property (take |=> activeVector == 8'($past(lowIdx)))
    else $error("active vector number wrong");
  AST_PLAIN_FORCED_NO_OPERATION: assert property (pushPc && !multi_vector_enable
    |-> forced_no_operation [*2] ##1 !forced_no_operation)
    else $error("plain latency cycles not two no-ops");
  AST_VEC: assert property (pushPc && multi_vector_enable |=> tableRead && pcLoad
    && pcValue == tableAddr ##1 pcLoad && pcValue == $past(tableData) ##1 inIsr)
    else $error("vectored entry sequence wrong");
  AST_PLAIN: assert property (pushPc && !multi_vector_enable
    |=> pcLoad && pcValue == isr_seq_pkg::ENTRY_ADDR ##1 inIsr && !pcLoad)
    else $error("single entry sequence wrong");
  AST_FORCED_NO_OPERATION: assert property (pushPc && multi_vector_enable
    |-> forced_no_operation [*3] ##1 !forced_no_operation)
    else $error("latency cycles not three no-ops");
  AST_RET: assert property (return_from_isr_instr.valid && inIsr && !pcLoad |=> popPc && pcLoad
    && pcValue == shadowCtx.pc)
    else $error("return did not reload pc");
  AST_RESTORE: assert property (popPc |-> ctxRestore == $past(return_from_isr_instr.restoreCtx))
    else $error("context restore does not follow operand");
  cover property (pushPc && multi_vector_enable);
  cover property (pushPc && !multi_vector_enable);
  cover property (ctxRestore);
  cover property (popPc && !ctxRestore);
endmodule
bind interrupt_entry_return_sequencer isr_seq_monitor #(.SRC(SRC)) i_monitor (.*);
`default_nettype wire

// *** verif/isr_far_end.sv ***
// Far side: vector table memory and an instruction pipeline.
// Assumes the table is read combinationally within one cycle.
`timescale 1ns/1ps
`default_nettype none
module isr_far_end (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [20:0] tableAddr,
  output logic [20:0] tableData,
  output logic instrDone
);
  logic [1:0] cyclesLeft_reg;
  // Scrambled contents so a wrong entry read shows up
  assign tableData = tableAddr ^ 21'h15a5a5;
  // Instructions last one to three cycles at random
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cyclesLeft_reg <= 2'h0;
      instrDone <= 1'b0;
    end else begin
      instrDone <= cyclesLeft_reg == 2'h1;
      cyclesLeft_reg <= (cyclesLeft_reg <= 2'h1) ? 2'($urandom_range(3, 1)) : cyclesLeft_reg - 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** verif/interrupt_entry_return_sequencer_bench.sv ***
// Self-checking bench for the interrupt sequencer.
// Assumes the far-side model supplies table data and instruction ends.
`timescale 1ns/1ps
`default_nettype none
module interrupt_entry_return_sequencer_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [63:0] irqFlags = '0;
  logic globalEnable = 1'b0;
  logic multi_vector_enable = 1'b0;
  logic [20:0] vector_table_base = '0;
  isr_seq_pkg::ctx_t liveCtx = '0;
  isr_seq_pkg::ret_req_t return_from_isr_instr = '0;
  logic instrDone, forced_no_operation, tableRead, pcLoad, pushPc, popPc, ctxRestore, inIsr;
  logic [20:0] tableData, tableAddr, pcValue, base;
  isr_seq_pkg::ctx_t shadowCtx, ctx;
  logic [7:0] activeVector;
  logic [21:0] expQ[$];
  logic [21:0] e;
  logic [124:0] expEntry[$];
  logic [124:0] f;
  logic restore;
  int numErrors = 0;
  int checked = 0;
  int cycles = 0;
  int idx;
  interrupt_entry_return_sequencer i_dut (.*);
  isr_far_end i_far (.*);
  always #2.5 sys_clk = ~sys_clk;
  task automatic endOfTest();
    if (numErrors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Each pc load takes the oldest note; a hang ends the run as a failure
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      numErrors++;
      endOfTest();
    end
    if (!rst && pcLoad === 1'b1) begin
      checked++;
      e = expQ.pop_front();
      if (e !== {ctxRestore, pcValue}) begin
        $display("MISMATCH pcLoad expected %h seen %h", e, {ctxRestore, pcValue});
        numErrors++;
      end
    end
    if (!rst && pushPc === 1'b1) begin
      checked++;
      f = expEntry.pop_front();
      if (f !== {activeVector, shadowCtx}) begin
        $display("MISMATCH entry expected %h seen %h", f, {activeVector, shadowCtx});
        numErrors++;
      end
    end
  end
  // A refused stray return, one entry, then one return, per pass
  initial begin
    void'($urandom(32'hc9a89b1a));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // Flags with the global enable low must start no entry
    irqFlags <= '1;
    repeat (8) @(posedge sys_clk);
    irqFlags <= '0;
    globalEnable <= 1'b1;
    for (int n = 0; n < 24; n++) begin
      @(posedge sys_clk);
      return_from_isr_instr <= '{1'b1, 1'b1};
      idx = $urandom_range(63, 0);
      base = 21'($urandom & 32'hfffff);
      ctx = 117'({$urandom, $urandom, $urandom, $urandom});
      @(posedge sys_clk);
      return_from_isr_instr <= '0;
      irqFlags <= ({$urandom, $urandom} & (~64'h0 << idx)) | (64'h1 << idx);
      multi_vector_enable <= n[0];
      vector_table_base <= base;
      liveCtx <= ctx;
      expEntry.push_back({8'(idx), ctx});
      if (n[0]) begin
        expQ.push_back({1'b0, base + 21'(2 * idx)});
        expQ.push_back({1'b0, (base + 21'(2 * idx)) ^ 21'h15a5a5});
      end else expQ.push_back({1'b0, isr_seq_pkg::ENTRY_ADDR});
      wait (inIsr === 1'b1);
      @(posedge sys_clk);
      restore = 1'($urandom_range(1, 0));
      irqFlags <= '0;
      liveCtx <= ~ctx;
      return_from_isr_instr <= '{1'b1, restore};
      expQ.push_back({restore, ctx.pc});
      @(posedge sys_clk);
      return_from_isr_instr <= '0;
    end
    repeat (4) @(posedge sys_clk);
    checked++;
    if (expQ.size() + expEntry.size() != 0) begin
      $display("MISMATCH queue expected 0 seen %0d", expQ.size() + expEntry.size());
      numErrors++;
    end
    endOfTest();
  end
endmodule
`default_nettype wire
